// ===== acdc_edge_sync.sv
// Two-stage synchroniser with registered rising edge pulse
`timescale 1ns/1ps
`default_nettype none

module acdc_edge_sync (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic async_in,
	output logic      level_out,
	output logic      rise_out
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic rise_r;
	logic rise_nxt;

	always_comb begin
		rise_nxt = s2_r & ~s3_r;
	end

	// First stage feeds only the second stage
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_r   <= 1'b0;
			s2_r   <= 1'b0;
			s3_r   <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			s1_r   <= async_in;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			rise_r <= rise_nxt;
		end
	end

	assign level_out = s3_r;
	assign rise_out  = rise_r;

endmodule : acdc_edge_sync

`default_nettype wire

// ===== acdc_mux_model.sv
// Behavioural multiplexer and sensor side: frame sync pulses and slot steps
`timescale 1ns/1ps
`default_nettype none
module acdc_mux_model (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic       frame_go,
	input wire logic       accum_in,
	input wire logic [1:0] step_gap,
	input wire logic       slot_busy,
	output logic           mux_frame_sync,
	output logic           accum_interval_end,
	output logic           slot_step
);
	logic [1:0] hi_r;
	logic [1:0] gc_r;
	// Steps keep coming while busy, so with step_gap 0 one lands after the frame ends
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mux_frame_sync <= 1'b0;
			accum_interval_end <= 1'b0;
			slot_step <= 1'b0;
			hi_r <= 2'h0;
			gc_r <= 2'h0;
		end else begin
			slot_step <= 1'b0;
			if (frame_go) begin
				mux_frame_sync <= 1'b1;
				accum_interval_end <= accum_in;
				hi_r <= 2'h3;
			end else if (hi_r != 2'h0) begin
				hi_r <= hi_r - 2'h1;
				if (hi_r == 2'h1) mux_frame_sync <= 1'b0;
			end
			if (gc_r != 2'h0) gc_r <= gc_r - 2'h1;
			else if (slot_busy) begin
				slot_step <= 1'b1;
				gc_r <= step_gap;
			end
		end
	end
endmodule : acdc_mux_model
`default_nettype wire

// ===== acdc_pkg.sv
// Constants and types shared by the converter chop and differential control block
package acdc_pkg;

	// ==================================================================
	// Register bus shape
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// ==================================================================
	// Register offsets
	localparam logic [15:0] OFS_BG_CHOP  = 16'h2106;
	localparam logic [15:0] OFS_DIFF     = 16'h210C;
	localparam logic [15:0] OFS_RS_CHOP  = 16'h2709;
	localparam logic [15:0] OFS_STATUS   = 16'h2710;

	// ==================================================================
	// Field positions
	localparam int unsigned BG_SEL_LSB   = 2;
	localparam int unsigned DIFF_LSB     = 4;
	localparam int unsigned RS_SEL_LSB   = 6;
	localparam int unsigned ST_BG_BIT    = 0;
	localparam int unsigned ST_RS_BIT    = 1;
	localparam int unsigned ST_BUSY_BIT  = 2;
	localparam int unsigned NUM_PAIRS    = 4;

	// ==================================================================
	// Reset values
	localparam logic [1:0] BG_SEL_RST    = 2'h0;
	localparam logic [1:0] RS_SEL_RST    = 2'h0;
	localparam logic [3:0] DIFF_RST      = 4'h0;
	localparam logic       CHOP_RST      = 1'b0;
	localparam logic [7:0] RDATA_RST     = 8'h00;

	// ==================================================================
	// Chop selection encodings
	localparam logic [1:0] CHOP_AUTO_A   = 2'h0;
	localparam logic [1:0] CHOP_POS      = 2'h1;
	localparam logic [1:0] CHOP_NEG      = 2'h2;
	localparam logic [1:0] CHOP_AUTO_B   = 2'h3;
	localparam logic       POL_POS       = 1'b0;
	localparam logic       POL_NEG       = 1'b1;

	// ==================================================================
	// Slot sequencer states
	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_RUN  = 1'b1
	} acdc_seq_state_t;

endpackage : acdc_pkg

// ===== acdc_slot_seq.sv
// Multiplexer slot sequencer for single-ended and paired current inputs
`timescale 1ns/1ps
`default_nettype none

module acdc_slot_seq
	import acdc_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic                 frame_start,
	input  wire logic                 slot_step,
	input  wire logic [NUM_PAIRS-1:0] diff_en,
	output logic      [2:0]           slot_input,
	output logic                      slot_diff,
	output logic                      slot_busy
);

	acdc_seq_state_t        state_r;
	acdc_seq_state_t        state_nxt;
	logic [1:0]             pair_r;
	logic [1:0]             pair_nxt;
	logic                   half_r;
	logic                   half_nxt;
	logic [NUM_PAIRS-1:0]   snap_r;
	logic [NUM_PAIRS-1:0]   snap_nxt;
	logic                   diff_r;
	logic                   diff_nxt;

	// Pairing is frozen per frame so a mid-frame write cannot split a pair
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_snap
			always_comb begin
				snap_nxt[gi] = frame_start ? diff_en[gi] : snap_r[gi];
			end
		end
	endgenerate

	always_comb begin
		state_nxt = state_r;
		pair_nxt  = pair_r;
		half_nxt  = half_r;
		if (frame_start) begin
			state_nxt = SEQ_RUN;
			pair_nxt  = 2'h0;
			half_nxt  = 1'b0;
		end else begin
			case (state_r)
				SEQ_IDLE: begin
					state_nxt = SEQ_IDLE;
				end
				SEQ_RUN: begin
					if (slot_step) begin
						if (snap_r[pair_r] || half_r) begin
							half_nxt = 1'b0;
							if (pair_r == 2'h3) begin
								state_nxt = SEQ_IDLE;
							end else begin
								pair_nxt = pair_r + 2'h1;
							end
						end else begin
							half_nxt = 1'b1;
						end
					end
				end
				default: begin
					state_nxt = SEQ_IDLE;
				end
			endcase
		end
	end

	// Registered so the pin comes straight from a flop, same cycle as the slot
	always_comb begin
		diff_nxt = snap_nxt[pair_nxt] & (state_nxt == SEQ_RUN);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= SEQ_IDLE;
			pair_r  <= 2'h0;
			half_r  <= 1'b0;
			snap_r  <= DIFF_RST;
			diff_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pair_r  <= pair_nxt;
			half_r  <= half_nxt;
			snap_r  <= snap_nxt;
			diff_r  <= diff_nxt;
		end
	end

	assign slot_input = {pair_r, half_r};
	assign slot_diff  = diff_r;
	assign slot_busy  = (state_r == SEQ_RUN);

endmodule : acdc_slot_seq

`default_nettype wire

// ===== acdc_top.sv
// Bandgap and remote sensor chop control with current input pairing
//
// Overview of operation
// - Bandgap select: 00/11 toggle, 01 positive, 10 reversed
// - Bandgap chop changes only on frame-sync rise
// - Toggle mode holds at accumulation-end edge
// - Remote select: 00/11 flip per frame, 01/10 fixed
// - Four pair-enable bits 4..7, reset single-ended
`timescale 1ns/1ps
`default_nettype none

module acdc_top (
	input  wire logic                       mclk,
	input  wire logic                       rstn,
	input  wire logic [acdc_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [acdc_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [acdc_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                       mux_frame_sync,
	input  wire logic                       accum_interval_end,
	input  wire logic                       slot_step,
	output logic                            bandgap_chop,
	output logic                            remote_chop,
	output logic      [2:0]                 slot_input,
	output logic                            slot_diff,
	output logic                            slot_busy
);

	import acdc_pkg::*;

	// ==================================================================
	// Software-visible configuration
	logic [1:0]           bandgap_chop_select_r;
	logic [1:0]           bandgap_chop_select_nxt;
	logic [1:0]           remote_sensor_chop_select_r;
	logic [1:0]           remote_sensor_chop_select_nxt;
	logic [NUM_PAIRS-1:0] diff_en_r;
	logic [NUM_PAIRS-1:0] diff_en_nxt;
	logic [DATA_W-1:0]    rdata_r;
	logic [DATA_W-1:0]    rdata_nxt;

	logic                 pair01_differential_enable;
	logic                 pair23_differential_enable;
	logic                 pair45_differential_enable;
	logic                 pair67_differential_enable;

	assign pair01_differential_enable = diff_en_r[0];
	assign pair23_differential_enable = diff_en_r[1];
	assign pair45_differential_enable = diff_en_r[2];
	assign pair67_differential_enable = diff_en_r[3];

	// ==================================================================
	// Applied chop state
	logic                 bg_chop_r;
	logic                 bg_chop_nxt;
	logic                 rs_chop_r;
	logic                 rs_chop_nxt;

	// ==================================================================
	// Slot sequencer outputs; slot_busy_w is also read back through the status register
	logic [2:0]           slot_input_w;
	logic                 slot_diff_w;
	logic                 slot_busy_w;

	// ==================================================================
	// Frame sync from the multiplexer pin
	logic                 frame_rise;

	// Only the rising edge acts, so the synchronised level is left open
	acdc_edge_sync u_frame_sync (
		.mclk      (mclk),
		.rstn      (rstn),
		.async_in  (mux_frame_sync),
		.level_out (),
		.rise_out  (frame_rise)
	);

	// ==================================================================
	// Register writes
	always_comb begin
		bandgap_chop_select_nxt       = bandgap_chop_select_r;
		remote_sensor_chop_select_nxt = remote_sensor_chop_select_r;
		diff_en_nxt                   = diff_en_r;
		if (reg_wr) begin
			case (reg_addr)
				OFS_BG_CHOP: begin
					bandgap_chop_select_nxt = reg_wdata[BG_SEL_LSB +: 2];
				end
				OFS_DIFF: begin
					diff_en_nxt = reg_wdata[DIFF_LSB +: NUM_PAIRS];
				end
				OFS_RS_CHOP: begin
					remote_sensor_chop_select_nxt = reg_wdata[RS_SEL_LSB +: 2];
				end
				default: begin
					diff_en_nxt = diff_en_r;
				end
			endcase
		end
	end

	// ==================================================================
	// Register reads, data one cycle after the strobe
	always_comb begin
		rdata_nxt = RDATA_RST;
		if (reg_rd) begin
			case (reg_addr)
				OFS_BG_CHOP: begin
					rdata_nxt[BG_SEL_LSB +: 2] = bandgap_chop_select_r;
				end
				OFS_DIFF: begin
					rdata_nxt[DIFF_LSB +: NUM_PAIRS] = diff_en_r;
				end
				OFS_RS_CHOP: begin
					rdata_nxt[RS_SEL_LSB +: 2] = remote_sensor_chop_select_r;
				end
				OFS_STATUS: begin
					rdata_nxt[ST_BG_BIT]   = bg_chop_r;
					rdata_nxt[ST_RS_BIT]   = rs_chop_r;
					rdata_nxt[ST_BUSY_BIT] = slot_busy_w;
				end
				default: begin
					rdata_nxt = RDATA_RST;
				end
			endcase
		end
	end

	// ==================================================================
	// Chop state updates on the frame-sync rising edge
	always_comb begin
		bg_chop_nxt = bg_chop_r;
		rs_chop_nxt = rs_chop_r;
		if (frame_rise) begin
			case (bandgap_chop_select_r)
				CHOP_POS: begin
					bg_chop_nxt = POL_POS;
				end
				CHOP_NEG: begin
					bg_chop_nxt = POL_NEG;
				end
				CHOP_AUTO_A, CHOP_AUTO_B: begin
					// Hold across the closing edge so each interval sees both halves
					bg_chop_nxt = accum_interval_end ? bg_chop_r : ~bg_chop_r;
				end
				default: begin
					bg_chop_nxt = bg_chop_r;
				end
			endcase
			case (remote_sensor_chop_select_r)
				CHOP_POS: begin
					rs_chop_nxt = POL_POS;
				end
				CHOP_NEG: begin
					rs_chop_nxt = POL_NEG;
				end
				CHOP_AUTO_A, CHOP_AUTO_B: begin
					rs_chop_nxt = ~rs_chop_r;
				end
				default: begin
					rs_chop_nxt = rs_chop_r;
				end
			endcase
		end
	end

	// ==================================================================
	// State registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bandgap_chop_select_r       <= BG_SEL_RST;
			remote_sensor_chop_select_r <= RS_SEL_RST;
			diff_en_r                   <= DIFF_RST;
			rdata_r                     <= RDATA_RST;
			bg_chop_r                   <= CHOP_RST;
			rs_chop_r                   <= CHOP_RST;
		end else begin
			bandgap_chop_select_r       <= bandgap_chop_select_nxt;
			remote_sensor_chop_select_r <= remote_sensor_chop_select_nxt;
			diff_en_r                   <= diff_en_nxt;
			rdata_r                     <= rdata_nxt;
			bg_chop_r                   <= bg_chop_nxt;
			rs_chop_r                   <= rs_chop_nxt;
		end
	end

	// ==================================================================
	// Multiplexer slot sequence
	acdc_slot_seq u_slot_seq (
		.mclk        (mclk),
		.rstn        (rstn),
		.frame_start (frame_rise),
		.slot_step   (slot_step),
		.diff_en     ({pair67_differential_enable, pair45_differential_enable,
		               pair23_differential_enable, pair01_differential_enable}),
		.slot_input  (slot_input_w),
		.slot_diff   (slot_diff_w),
		.slot_busy   (slot_busy_w)
	);

	assign reg_rdata    = rdata_r;
	assign bandgap_chop = bg_chop_r;
	assign remote_chop  = rs_chop_r;
	assign slot_input   = slot_input_w;
	assign slot_diff    = slot_diff_w;
	assign slot_busy    = slot_busy_w;

endmodule : acdc_top

`default_nettype wire

// ===== acdc_top_monitor.sv
// Assertion checker for the chop and pairing control block
`timescale 1ns/1ps
`default_nettype none
module acdc_top_monitor
	import acdc_pkg::*;
(
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [2:0]        slot_input,
	input wire logic              mclk,
	input wire logic              rstn,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic              mux_frame_sync,
	input wire logic              accum_interval_end,
	input wire logic              slot_step,
	input wire logic              bandgap_chop,
	input wire logic              remote_chop,
	input wire logic              slot_diff,
	input wire logic              slot_busy
);
	// ==========
	// Shadow state
	logic [2:0] q_r;
	logic       r_r;
	logic [1:0] bg_r;
	logic [1:0] rs_r;
	logic [3:0] df_r;
	wire        auto_bg = bg_r[0] == bg_r[1];
	wire        auto_rs = rs_r[0] == rs_r[1];
	// Same depth as the pin synchroniser, so r_r lines up with the chop edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			q_r <= 3'h0;
			r_r <= 1'b0;
			bg_r <= 2'h0;
			rs_r <= 2'h0;
			df_r <= 4'h0;
		end else begin
			q_r <= {q_r[1:0], mux_frame_sync};
			r_r <= q_r[1] & ~q_r[2];
			if (reg_wr && reg_addr == OFS_BG_CHOP) bg_r <= reg_wdata[3:2];
			if (reg_wr && reg_addr == OFS_RS_CHOP) rs_r <= reg_wdata[7:6];
			if (reg_wr && reg_addr == OFS_DIFF) df_r <= reg_wdata[7:4];
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence s_bg_flip;
		r_r && auto_bg && !accum_interval_end;
	endsequence
	sequence s_bg_hold;
		r_r && auto_bg && accum_interval_end;
	endsequence
	a_bg_no_edge: assert property (!r_r |=> $stable(bandgap_chop)) else $error("bandgap chop moved");
	a_rs_no_edge: assert property (!r_r |=> $stable(remote_chop)) else $error("remote chop moved");
	a_bg_fixed_sel: assert property (r_r && !auto_bg |=> bandgap_chop == $past(bg_r[1]))
		else $error("bandgap fixed wrong");
	a_bg_auto_flip: assert property (s_bg_flip |=> bandgap_chop != $past(bandgap_chop))
		else $error("bandgap no toggle");
	a_bg_accum_hold: assert property (s_bg_hold |=> $stable(bandgap_chop)) else $error("bandgap not held");
	a_rs_fixed_sel: assert property (r_r && !auto_rs |=> remote_chop == $past(rs_r[1]))
		else $error("remote fixed wrong");
	a_rs_auto_flip: assert property (r_r && auto_rs |=> remote_chop != $past(remote_chop))
		else $error("remote no flip");
	a_diff_read_back: assert property (reg_rd && reg_addr == OFS_DIFF |=> reg_rdata == {df_r, 4'h0})
		else $error("pair enables wrong");
	a_frame_first_slot: assert property (r_r |=> slot_busy && slot_input == 3'h0 && slot_diff == $past(df_r[0]))
		else $error("frame start slot wrong");
	a_diff_even_slot: assert property (slot_diff |-> !slot_input[0]) else $error("odd differential slot");
endmodule : acdc_top_monitor
bind acdc_top acdc_top_monitor i_mon (.reg_addr, .reg_wdata, .reg_rdata, .slot_input, .mclk, .rstn, .reg_wr,
	.reg_rd, .mux_frame_sync, .accum_interval_end, .slot_step, .bandgap_chop, .remote_chop, .slot_diff, .slot_busy);
`default_nettype wire

// ===== tb_acdc_top.sv
// Self-checking bench for the chop and pairing control block
`timescale 1ns/1ps
`default_nettype none
module tb_acdc_top;
	import acdc_pkg::*;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic [2:0]  slot_input;
	logic [1:0]  step_gap = 2'h0;
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        frame_go = 1'b0;
	logic        accum_in = 1'b0;
	logic        mux_frame_sync, accum_interval_end, slot_step;
	logic        bandgap_chop, remote_chop, slot_diff, slot_busy;
	logic        rd_d = 1'b0;
	logic        st_d = 1'b0;
	logic        bg = 1'b0;
	logic        rs = 1'b0;
	logic [4:0]  e;
	logic [7:0]  rq[$];
	logic [4:0]  sq[$];
	int          bad_count = 0;
	int          compares = 0;
	int          k;
	acdc_top i_dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mux_frame_sync,
		.accum_interval_end, .slot_step, .bandgap_chop, .remote_chop, .slot_input, .slot_diff, .slot_busy);
	acdc_mux_model i_far (.mclk, .rstn, .frame_go, .accum_in, .step_gap, .slot_busy, .mux_frame_sync,
		.accum_interval_end, .slot_step);
	initial forever #25 mclk = ~mclk;
	// ==========
	// Tasks
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wrt(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wrt
	task rdr(input logic [15:0] a, input logic [7:0] x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(x);
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask : rdr
	task frame(input logic [1:0] b, input logic [1:0] r, input logic [3:0] d, input logic a, input logic [1:0] g);
		int i;
		logic [4:0] sl[$];
		// Static task: the slot list would otherwise carry the last frame over
		sl.delete();
		wrt(OFS_BG_CHOP, (8'($urandom) & 8'hf3) | {4'h0, b, 2'h0});
		wrt(OFS_RS_CHOP, {r, 6'($urandom)});
		wrt(OFS_DIFF, {d, 4'($urandom)});
		rdr(OFS_BG_CHOP, {4'h0, b, 2'h0});
		rdr(OFS_RS_CHOP, {r, 6'h00});
		rdr(OFS_DIFF, {d, 4'h0});
		for (i = 0; i < 4; i++) begin
			if (d[i]) sl.push_back({2'b11, 2'(i), 1'b0});
			else begin
				sl.push_back({2'b10, 2'(i), 1'b0});
				sl.push_back({2'b10, 2'(i), 1'b1});
			end
		end
		void'(sl.pop_front());
		foreach (sl[j]) sq.push_back(sl[j]);
		sq.push_back(5'h00);
		if (b == CHOP_POS) bg = POL_POS;
		else if (b == CHOP_NEG) bg = POL_NEG;
		else if (!a) bg = ~bg;
		if (r == CHOP_POS) rs = POL_POS;
		else if (r == CHOP_NEG) rs = POL_NEG;
		else rs = ~rs;
		accum_in <= a;
		step_gap <= g;
		frame_go <= 1'b1;
		@(posedge mclk);
		frame_go <= 1'b0;
		repeat (6) @(posedge mclk);
		i = 0;
		while (slot_busy !== 1'b0 && i < 400) begin
			@(posedge mclk);
			i++;
		end
		if (i == 400) chk(8'h01, 8'h00);
		rdr(OFS_STATUS, {6'h00, rs, bg});
	endtask : frame
	task summarize;
		$display("bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	// ==========
	// Output watcher: oldest note against each result
	always @(posedge mclk) begin
		if (rd_d) chk(reg_rdata, rq.pop_front());
		if (st_d) begin
			e = sq.pop_front();
			if (e[4]) chk({3'h0, slot_busy, slot_diff, slot_input}, {3'h0, e});
			else chk({7'h00, slot_busy}, 8'h00);
		end
		rd_d = reg_rd;
		st_d = slot_step && slot_busy;
	end
	initial begin
		#1000000;
		bad_count++;
		summarize;
	end
	initial begin
		void'($urandom(32'h25b1afa1));
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rdr(OFS_BG_CHOP, 8'h00);
		rdr(OFS_RS_CHOP, 8'h00);
		rdr(OFS_DIFF, 8'h00);
		rdr(OFS_STATUS, 8'h00);
		wrt(16'h2107, 8'hff);
		rdr(16'h2107, 8'h00);
		frame(CHOP_AUTO_A, CHOP_AUTO_B, 4'hf, 1'b1, 2'h0);
		frame(CHOP_AUTO_B, CHOP_AUTO_A, 4'h0, 1'b0, 2'h3);
		for (k = 0; k < 16; k++) frame(2'(k), 2'(k >> 2), 4'($urandom), 1'($urandom), 2'($urandom));
		summarize;
	end
endmodule : tb_acdc_top
`default_nettype wire
